// file: core/pic_ctrl.sv
// Purpose: fixed-priority interrupt controller with APB registers
// Assumes: events synchronous to clk; CPU offers instruction boundaries
// Notes:   runs the 13-cycle automatic call on acknowledge
// Behaviour
// - fifteen interrupt sources accepted
// - per-source mask bit, one enables
// - global enable flag gates all requests
// - reset clears masks and global enable
// - vector read gives highest-priority unmasked pending vector
// - vector write clears all pending flags
// - masks at E0h/E1h; masked-away gives 0000h
// - one pending flip-flop per source
// - pending holds until serviced, reset, cleared
// - request needs mask and global enable
// - gpio and analog need extra qualification
// - 13-cycle call pushes PC high, low, flags
// - flags cleared on the edge that pushes them
// - return restores flags from retiFlags
// - lowest priority number served first
// - vector is four times priority number
// - blocks 2-9, columns 10-13, gpio, sleep
// - entry loads PC with vector address
// - program memory begins at 0x0040
// - general mask bit layout
// - block mask bit layout
//
// Implementation choice: the APB interface to the registers.
`include "pic_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl
    import pic_pkg::*;
#(
    parameter int AW = 12
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    // interrupt sources (levels, rising edge raises)
    input  wire logic          supplyEvt,
    input  wire logic [7:0]    digEvt,
    input  wire logic [3:0]    anaEvt,
    input  wire logic          gpioEvt,
    input  wire logic          sleepEvt,
    // source qualifiers
    input  wire logic          gpioPinArmed,
    input  wire logic [3:0]    anaSrcSel,
    // cpu side
    input  wire logic          instrBoundary,
    input  wire logic [15:0]   pcValue,
    input  wire logic          retiStrobe,
    input  wire logic [7:0]    retiFlags,
    output var  logic          irqReq,
    output var  logic          callBusy,
    output var  logic          pushValid,
    output var  logic [7:0]    pushData,
    output var  logic          pcLoadValid,
    output var  logic [15:0]   pcLoadAddr,
    output var  logic          globalIrqEnable
);

    // highest priority set bit; 0 means none
    function automatic logic [3:0] pic_top_prio(input logic [14:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                p = 4'(i + 1);
            end
        end
        return p;
    endfunction

    // vector address from priority number
    function automatic logic [15:0] pic_vec(input logic [3:0] p);
        logic [15:0] a;
        a = {12'h000, p} << `PIC_VEC_SHIFT;
        // table ends below program memory by construction
        if (a >= `PIC_PROG_START) begin
            a = `PIC_VEC_NONE;
        end
        return a;
    endfunction

    // mask registers laid out as a 15-bit enable per priority
    function automatic logic [14:0] pic_enables(input logic [7:0] g,
                                                input logic [7:0] b);
        logic [14:0] e;
        e = 15'h0000;
        e[`PIC_PEND_VMON] = g[`PIC_GEN_VMON];
        e[`PIC_PEND_DIG0 +: 8] = b;
        e[`PIC_PEND_ACOL0 +: 4] = g[`PIC_GEN_ACOL0 +: 4];
        e[`PIC_PEND_GPIO] = g[`PIC_GEN_GPIO];
        e[`PIC_PEND_SLEEP] = g[`PIC_GEN_SLEEP];
        return e;
    endfunction

    // register state
    logic [7:0]    genMask_reg, genMask_next;     // general mask
    logic [7:0]    blkMask_reg, blkMask_next;     // block mask
    logic [7:0]    flags_reg, flags_next;         // cpu flags
    logic [14:0]   pend_reg, pend_next;           // pending flags
    logic [14:0]   srcLast_reg, srcLast_next;     // source history
    // bus outputs
    logic [31:0]   prdata_reg, prdata_next;
    logic          pready_reg, pready_next;
    logic          pslverr_reg, pslverr_next;
    // sequencer
    pic_state_type state_reg, state_next;
    logic [3:0]    step_reg, step_next;           // call cycle
    logic [15:0]   savedPc_reg, savedPc_next;     // pc to push
    logic [15:0]   vecAddr_reg, vecAddr_next;     // vector latched
    logic          irqReq_reg, irqReq_next;
    logic          pushValid_reg, pushValid_next;
    logic [7:0]    pushData_reg, pushData_next;
    logic          pcLoad_reg, pcLoad_next;
    logic [15:0]   pcAddr_reg, pcAddr_next;

    // combinational helpers
    logic [14:0]   srcNow;      // qualified source levels
    logic [14:0]   srcRise;     // new events this cycle
    logic [14:0]   enables;     // mask bits per priority
    logic [14:0]   live;        // pending and unmasked
    logic [3:0]    topPrio;     // best live priority
    logic          wrDone;      // apb write completes
    logic          rdFirst;     // first access cycle of any transfer
    logic [9:0]    regIdx;      // word index
    logic          hit;         // mapped address

    // source assembly and gating
    always_comb begin
        srcNow = 15'h0000;
        srcNow[`PIC_PEND_VMON] = supplyEvt;
        srcNow[`PIC_PEND_DIG0 +: 8] = digEvt;
        // analog column counts only with its source selected
        srcNow[`PIC_PEND_ACOL0 +: 4] = anaEvt & anaSrcSel;
        // gpio needs gpioPinArmed set
        srcNow[`PIC_PEND_GPIO] = gpioEvt & gpioPinArmed;
        srcNow[`PIC_PEND_SLEEP] = sleepEvt;
        srcRise = srcNow & ~srcLast_reg;
        enables = pic_enables(genMask_reg, blkMask_reg);
        live = pend_reg & enables;
        topPrio = pic_top_prio(live);
        regIdx = paddr[11:2];
        hit = (regIdx == `PIC_IDX_GEN_MASK) || (regIdx == `PIC_IDX_BLK_MASK)
           || (regIdx == `PIC_IDX_VECTOR) || (regIdx == `PIC_IDX_FLAGS)
           || (regIdx == `PIC_IDX_PENDING);
        wrDone = psel && penable && pready_reg && pwrite;
        rdFirst = psel && penable && !pready_reg;
    end

    // apb answer: one wait state, data registered for the last cycle
    always_comb begin
        pready_next = psel && penable && !pready_reg;
        pslverr_next = 1'b0;
        prdata_next = prdata_reg;
        if (rdFirst) begin
            pslverr_next = !hit; // unmapped reports an error
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                unique case (regIdx)
                    `PIC_IDX_GEN_MASK: prdata_next[7:0] = genMask_reg;
                    `PIC_IDX_BLK_MASK: prdata_next[7:0] = blkMask_reg;
                    // best unmasked pending vector
                    `PIC_IDX_VECTOR: prdata_next[7:0] = pic_vec(topPrio)[7:0];
                    `PIC_IDX_FLAGS: prdata_next[7:0] = flags_reg;
                    `PIC_IDX_PENDING: prdata_next[14:0] = pend_reg;
                    default: prdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // mask registers; a write takes effect on the completing edge
    always_comb begin
        genMask_next = genMask_reg;
        blkMask_next = blkMask_reg;
        if (wrDone && regIdx == `PIC_IDX_GEN_MASK) begin
            genMask_next = pwdata[7:0];
        end
        if (wrDone && regIdx == `PIC_IDX_BLK_MASK) begin
            blkMask_next = pwdata[7:0];
        end
    end

    // flags register: call clear beats return, return beats software
    always_comb begin
        flags_next = flags_reg;
        if (wrDone && regIdx == `PIC_IDX_FLAGS) begin
            flags_next = pwdata[7:0];
        end
        if (retiStrobe) begin
            flags_next = retiFlags;
        end
        if (state_reg == PIC_CALL && step_reg == `PIC_STEP_FLG) begin
            // pushed copy holds the old value; live one drops to zero
            flags_next = `PIC_FLAGS_RST;
        end
    end

    // pending flags: clears first, new events win over any clear
    always_comb begin
        pend_next = pend_reg;
        srcLast_next = srcNow;
        if (wrDone && regIdx == `PIC_IDX_VECTOR) begin
            pend_next = 15'h0000;
        end
        if (state_reg == PIC_IDLE && irqReq_reg && instrBoundary
            && topPrio != 4'h0) begin
            pend_next[topPrio - 4'd1] = 1'b0;
        end
        pend_next = pend_next | srcRise;
    end

    // acknowledge sequencer and cpu request
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        savedPc_next = savedPc_reg;
        vecAddr_next = vecAddr_reg;
        pushValid_next = 1'b0;
        pushData_next = pushData_reg;
        pcLoad_next = 1'b0;
        pcAddr_next = pcAddr_reg;
        // request only with mask and global enable both set
        irqReq_next = (live != 15'h0000)
                   && flags_reg[`PIC_FLAG_IE] && state_reg == PIC_IDLE;
        unique case (state_reg)
            PIC_IDLE: begin
                // a request latched earlier is taken even if masked since
                if (irqReq_reg && instrBoundary) begin
                    state_next = PIC_CALL;
                    step_next = 4'h0;
                    savedPc_next = pcValue;
                    vecAddr_next = pic_vec(topPrio);
                    irqReq_next = 1'b0;
                end
            end
            PIC_CALL: begin
                irqReq_next = 1'b0;
                step_next = step_reg + 4'd1;
                unique case (step_reg)
                    `PIC_STEP_PCH: begin
                        pushValid_next = 1'b1;
                        pushData_next = savedPc_reg[15:8];
                    end
                    `PIC_STEP_PCL: begin
                        pushValid_next = 1'b1;
                        pushData_next = savedPc_reg[7:0];
                    end
                    `PIC_STEP_FLG: begin
                        pushValid_next = 1'b1;
                        pushData_next = flags_reg;
                    end
                    default: begin
                        pushValid_next = 1'b0;
                    end
                endcase
                if (step_reg == `PIC_CALL_LAST) begin
                    state_next = PIC_IDLE;
                    step_next = 4'h0;
                    pcLoad_next = 1'b1;
                    pcAddr_next = vecAddr_reg;
                end
            end
        endcase
    end

    // state registers; async reset loads constants only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            genMask_reg <= `PIC_MASK_RST;
            blkMask_reg <= `PIC_MASK_RST;
            flags_reg <= `PIC_FLAGS_RST;
            pend_reg <= 15'h0000;
            srcLast_reg <= 15'h0000;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            state_reg <= PIC_IDLE;
            step_reg <= 4'h0;
            savedPc_reg <= 16'h0000;
            vecAddr_reg <= `PIC_VEC_NONE;
            irqReq_reg <= 1'b0;
            pushValid_reg <= 1'b0;
            pushData_reg <= 8'h00;
            pcLoad_reg <= 1'b0;
            pcAddr_reg <= 16'h0000;
        end else begin
            genMask_reg <= genMask_next;
            blkMask_reg <= blkMask_next;
            flags_reg <= flags_next;
            pend_reg <= pend_next;
            srcLast_reg <= srcLast_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            state_reg <= state_next;
            step_reg <= step_next;
            savedPc_reg <= savedPc_next;
            vecAddr_reg <= vecAddr_next;
            irqReq_reg <= irqReq_next;
            pushValid_reg <= pushValid_next;
            pushData_reg <= pushData_next;
            pcLoad_reg <= pcLoad_next;
            pcAddr_reg <= pcAddr_next;
        end
    end

    // outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irqReq = irqReq_reg;
    assign callBusy = (state_reg == PIC_CALL);
    assign pushValid = pushValid_reg;
    assign pushData = pushData_reg;
    assign pcLoadValid = pcLoad_reg;
    assign pcLoadAddr = pcAddr_reg;
    assign globalIrqEnable = flags_reg[`PIC_FLAG_IE];

endmodule
`default_nettype wire

// file: pkg/pic_map.svh
// Purpose: register indices, field positions and timing counts
// Assumes: included by bare name
// Notes:   byte address of a register is four times its index
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
// register indices (byte address = index * 4)
`define PIC_IDX_GEN_MASK  10'h0e0
`define PIC_IDX_BLK_MASK  10'h0e1
`define PIC_IDX_VECTOR    10'h0e2
`define PIC_IDX_FLAGS     10'h0e3
`define PIC_IDX_PENDING   10'h0e4
// reset values
`define PIC_MASK_RST      8'h00
`define PIC_FLAGS_RST     8'h00
// flags register: global enable bit position
`define PIC_FLAG_IE       0
// general mask field positions
`define PIC_GEN_VMON      0
`define PIC_GEN_ACOL0     1
`define PIC_GEN_GPIO      5
`define PIC_GEN_SLEEP     6
// pending vector bit positions (bit = priority - 1)
`define PIC_PEND_VMON     0
`define PIC_PEND_DIG0     1
`define PIC_PEND_ACOL0    9
`define PIC_PEND_GPIO     13
`define PIC_PEND_SLEEP    14
// number of sources
`define PIC_NSRC          15
// automatic call sequence
`define PIC_CALL_LAST     4'd12
`define PIC_STEP_PCH      4'd0
`define PIC_STEP_PCL      4'd1
`define PIC_STEP_FLG      4'd2
// vector table geometry
`define PIC_VEC_SHIFT     2
`define PIC_PROG_START    16'h0040
`define PIC_VEC_NONE      16'h0000
`endif

// file: pkg/pic_pkg.sv
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes:   constants live in pic_map.svh
package pic_pkg;
    // acknowledge sequencer states
    typedef enum logic {
        PIC_IDLE,
        PIC_CALL
    } pic_state_type;
endpackage

// file: sim/pic_ctrl_chk.sv
// Purpose: port-level checker of the interrupt controller
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   bound onto every instance of the controller
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_chk (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // apb handshake
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic        pready,
    // cpu side
    input  wire logic        instrBoundary,
    input  wire logic        retiStrobe,
    input  wire logic        irqReq,
    input  wire logic        callBusy,
    input  wire logic        pushValid,
    input  wire logic [7:0]  pushData,
    input  wire logic        pcLoadValid,
    input  wire logic [15:0] pcLoadAddr,
    input  wire logic        globalIrqEnable
);
    logic [4:0] busyCnt;     // busy cycles of the running call
    logic [4:0] busyCntNext; // next count, cleared when idle
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // count the call length; a counter, since 13 is too long to unroll
    always_comb begin
        busyCntNext = callBusy ? busyCnt + 5'h01 : 5'h00;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busyCnt <= 5'h00;
        end else begin
            busyCnt <= busyCntNext;
        end
    end
    // core accepts the request at this edge
    sequence takeSeq;
        irqReq && instrBoundary && !callBusy;
    endsequence
    // three stacked bytes in a row, then quiet
    sequence pushSeq;
        pushValid [*3] ##1 !pushValid;
    endsequence
    a_call_pushes: assert property (takeSeq |=> callBusy ##1 pushSeq)
        else $error("call did not push three bytes");
    a_call_length: assert property ($fell(callBusy) |-> busyCnt == 5'd13 && pcLoadValid)
        else $error("call length or pc load wrong");
    a_flags_clear: assert property (takeSeq |-> ##4 pushData[0] ##[0:1] !globalIrqEnable)
        else $error("flags not pushed then cleared");
    a_irq_gated: assert property (irqReq |-> globalIrqEnable || $past(globalIrqEnable))
        else $error("request without global enable");
    a_busy_quiet: assert property (callBusy |-> !irqReq)
        else $error("request raised during call");
    a_vector_table: assert property (pcLoadValid |-> pcLoadAddr[1:0] == 2'b00 && pcLoadAddr < 16'h0040)
        else $error("loaded address outside vector table");
    // checked one edge on: flops hold no value before the first reset edge
    a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !globalIrqEnable && !irqReq)
        else $error("enable or request set in reset");
    a_enable_cause: assert property ($fell(globalIrqEnable) |-> $past(callBusy) || $past(retiStrobe) || $past(pready && pwrite))
        else $error("global enable fell without cause");
    a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
        else $error("apb answer not in second access cycle");
endmodule
bind pic_ctrl pic_ctrl_chk chk (.clk, .rst_b, .psel, .penable, .pwrite, .pready, .instrBoundary,
    .retiStrobe, .irqReq, .callBusy, .pushValid, .pushData, .pcLoadValid, .pcLoadAddr,
    .globalIrqEnable);
`default_nettype wire

// file: sim/pic_cpu_model.sv
// Purpose: behavioural cpu core taking interrupts from the controller
// Assumes: bench stalls it through holdOff
// Notes:   keeps the stacked bytes of the last call for the bench
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // bench control
    input  wire logic        holdOff,
    // from the controller
    input  wire logic        pushValid,
    input  wire logic [7:0]  pushData,
    input  wire logic        pcLoadValid,
    input  wire logic [15:0] pcLoadAddr,
    // to the controller
    output var  logic        instrBoundary,
    output var  logic [15:0] pcValue,
    output var  logic        retiStrobe,
    output var  logic [7:0]  retiFlags
);
    logic [7:0]  stack [0:2]; // bytes of the last call
    int          pushCount;   // bytes pushed in this call
    int          loadCount;   // calls completed
    logic [15:0] lastVector;  // last address loaded into the pc
    // a stalled core is inside a long instruction, no boundary
    assign instrBoundary = !holdOff;
    assign pcValue       = 16'h02c4; // code runs above the vector table
    // stack the pushed bytes and note the jump
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pushCount  <= 0;
            loadCount  <= 0;
            lastVector <= 16'hffff;
        end else begin
            if (pushValid) begin
                stack[pushCount % 3] <= pushData;
                pushCount            <= pushCount + 1;
            end
            if (pcLoadValid) begin
                lastVector <= pcLoadAddr;
                loadCount  <= loadCount + 1;
                pushCount  <= 0;
            end
        end
    end
    // return pops the saved flags; the bus then no longer holds them
    task automatic doReti();
        @(posedge clk);
        retiFlags  <= stack[2];
        retiStrobe <= 1'b1;
        @(posedge clk);
        retiStrobe <= 1'b0;
        retiFlags  <= ~stack[2];
    endtask
    initial begin
        retiStrobe = 1'b0;
        retiFlags  = 8'h00;
    end
endmodule
`default_nettype wire

// file: sim/priority_interrupt_controller_test.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: apb slave answers in the second access cycle
// Notes:   sources are levels; the bench makes their rising edges
`include "pic_map.svh"
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_test;
    localparam logic [9:0] idxGen = `PIC_IDX_GEN_MASK; // register word indices
    localparam logic [9:0] idxBlk = `PIC_IDX_BLK_MASK;
    localparam logic [9:0] idxVec = `PIC_IDX_VECTOR;
    localparam logic [9:0] idxFlg = `PIC_IDX_FLAGS;
    localparam logic [9:0] idxPnd = `PIC_IDX_PENDING;
    logic        clk = 1'b0, rst_b = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic        supplyEvt, gpioEvt, sleepEvt, gpioPinArmed, holdOff, rdErr;
    logic [7:0]  digEvt, retiFlags, pushData, gm, bm;
    logic [3:0]  anaEvt, anaSrcSel;
    logic [15:0] pcValue, pcLoadAddr;
    logic        instrBoundary, retiStrobe, irqReq, callBusy, pushValid, pcLoadValid;
    logic        globalIrqEnable;
    int          errors, testsRun;
    // design and far-side core
    pic_ctrl dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .supplyEvt, .digEvt, .anaEvt, .gpioEvt, .sleepEvt, .gpioPinArmed, .anaSrcSel,
        .instrBoundary, .pcValue, .retiStrobe, .retiFlags, .irqReq, .callBusy, .pushValid,
        .pushData, .pcLoadValid, .pcLoadAddr, .globalIrqEnable);
    pic_cpu_model cpu (.clk, .rst_b, .holdOff, .pushValid, .pushData, .pcLoadValid,
        .pcLoadAddr, .instrBoundary, .pcValue, .retiStrobe, .retiFlags);
    always #12.5 clk = ~clk; // 40 MHz
    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one counted comparison
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            errors++;
            results();
        end
    endtask
    // read a register and compare
    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input string name);
        apb(idx, 1'b0, 8'h00);
        chk(name, exp, rdData);
    endtask
    // wait for a given number of completed calls, bounded
    task automatic waitLoads(input int target);
        int n;
        n = 0;
        while (cpu.loadCount != target && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            errors++;
            results();
        end
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, supplyEvt, gpioEvt, sleepEvt} = '0;
        {digEvt, anaEvt, gpioPinArmed, holdOff} = '0;
        anaSrcSel = 4'h5; // columns 1 and 3 not selected
        errors    = 0;
        testsRun  = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rchk(idxGen, 32'h00000000, "general mask reset");
        rchk(idxBlk, 32'h00000000, "block mask reset");
        rchk(idxFlg, 32'h00000000, "flags reset");
        apb(10'h0f0, 1'b0, 8'h00);
        chk("unmapped error", 32'h00000001, 32'(rdErr));
        apb(idxGen, 1'b1, 8'hff);
        rchk(idxGen, 32'h000000ff, "general mask");
        apb(idxBlk, 1'b1, 8'h5a);
        rchk(idxBlk, 32'h0000005a, "block mask");
        // all sources at once, gpio and two columns unqualified
        apb(idxBlk, 1'b1, 8'hff);
        {supplyEvt, digEvt, anaEvt, gpioEvt, sleepEvt} <= '1;
        repeat (3) @(posedge clk);
        rchk(idxPnd, 32'h00004bff, "pending unqualified");
        gpioPinArmed <= 1'b1;
        anaSrcSel    <= 4'hf;
        repeat (3) @(posedge clk);
        rchk(idxPnd, 32'h00007fff, "pending all");
        // walk the priorities down by masking each winner
        gm = 8'h7f;
        bm = 8'hff;
        apb(idxGen, 1'b1, gm);
        for (int p = 1; p <= 15; p++) begin
            rchk(idxVec, 32'(4 * p), "vector");
            if (p == 1) begin
                gm[0] = 1'b0;
            end else if (p <= 9) begin
                bm[p - 2] = 1'b0;
            end else begin
                gm[p - 9] = 1'b0;
            end
            apb(idxGen, 1'b1, gm);
            apb(idxBlk, 1'b1, bm);
        end
        rchk(idxVec, 32'h00000000, "vector all masked");
        rchk(idxPnd, 32'h00007fff, "pending kept");
        apb(idxVec, 1'b1, 8'h5a);
        rchk(idxPnd, 32'h00000000, "pending after clear");
        // two requests raised at a stalled core, the second taken after the return
        {supplyEvt, digEvt, anaEvt, gpioEvt, sleepEvt} <= '0;
        apb(idxGen, 1'b1, 8'h7f);
        apb(idxBlk, 1'b1, 8'hff);
        holdOff   <= 1'b1;
        digEvt[3] <= 1'b1;
        sleepEvt  <= 1'b1;
        apb(idxFlg, 1'b1, 8'h01);
        repeat (4) @(posedge clk);
        holdOff <= 1'b0;
        waitLoads(1);
        chk("first vector", 32'h00000014, 32'(cpu.lastVector));
        chk("pushed pc high", 32'h00000002, 32'(cpu.stack[0]));
        chk("pushed pc low", 32'h000000c4, 32'(cpu.stack[1]));
        chk("pushed flags", 32'h00000001, 32'(cpu.stack[2]));
        chk("enable in handler", 32'h00000000, 32'(globalIrqEnable));
        rchk(idxPnd, 32'h00004000, "pending after ack");
        cpu.doReti();
        waitLoads(2);
        chk("second vector", 32'h0000003c, 32'(cpu.lastVector));
        // mask the only pending source as the core takes it
        digEvt    <= 8'h00;
        sleepEvt  <= 1'b0;
        holdOff   <= 1'b1;
        supplyEvt <= 1'b1;
        apb(idxFlg, 1'b1, 8'h01);
        for (int n = 0; n < 20 && irqReq !== 1'b1; n++) begin
            @(posedge clk);
        end
        apb(idxGen, 1'b1, 8'h7e);
        holdOff <= 1'b0;
        waitLoads(3);
        chk("masked vector", 32'h00000000, 32'(cpu.lastVector));
        // reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rchk(idxGen, 32'h00000000, "general mask after reset");
        rchk(idxFlg, 32'h00000000, "flags after reset");
        results();
    end
endmodule
`default_nettype wire
